// file: core/dsm_maps.sv
// Purpose: done, bypass and last-descriptor maps plus the category scan
// Assumes: engine inputs come from logic on pclk; valid flags are levels
// Notes: a presented descriptor is held until the engine reports completion or its bypass bit gets set
`timescale 1ns/10ps
module dsm_maps
    import dsm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    dsm_if.dev bus,
    input wire logic [2:0][31:0] desc_valid,
    input wire logic [2:0] cmpl,
    input wire logic [2:0] jump,
    input wire logic [2:0][4:0] jump_ptr,
    output logic [2:0] active,
    output logic [2:0][4:0] scan_index,
    output logic [2:0] wrap
);

    // map storage, one word of each kind per category
    logic [31:0] bypass_map [DSM_NCAT];
    logic [31:0] last_map [DSM_NCAT];
    logic [31:0] done_map [DSM_NCAT];
    logic [31:0] next_done [DSM_NCAT];
    logic acc_hit;
    logic [1:0] acc_cat;
    logic [1:0] acc_slot;
    logic [3:0] acc_nib;
    logic acc_rd;
    logic acc_wr;

    // position after p: wraps at the marker or after the top slot
    function automatic logic [4:0] dsm_step(input logic [4:0] p,
                                            input logic [31:0] lm);
        logic [4:0] r;
        r = p + 5'h01;
        if (lm[p] || (p == DSM_POS_TOP)) begin
            r = DSM_POS_FIRST;
        end
        return r;
    endfunction

    // both helpers share one wrap test, so the step and the
    // wrap pulse can never disagree
    // true when the step from p wraps the scan
    function automatic logic dsm_wraps(input logic [4:0] p,
                                       input logic [31:0] lm);
        return lm[p] || (p == DSM_POS_TOP);
    endfunction

    // address decode: category from bits 7:4, word slot from bits 3:2
    always_comb begin
        acc_nib = bus.addr[7:4] - DSM_ISO_DONE_OFS[7:4];
        acc_cat = acc_nib[1:0];
        acc_slot = bus.addr[3:2];
        acc_hit = (bus.addr[11:8] == DSM_ISO_DONE_OFS[11:8])
            && (bus.addr[7:4] >= DSM_ISO_DONE_OFS[7:4])
            && (bus.addr[7:4] <= DSM_ASYNC_DONE_OFS[7:4])
            && (acc_slot != 2'h3)
            && (bus.addr[1:0] == 2'h0);
        acc_rd = bus.req && !bus.wr && acc_hit;
        acc_wr = bus.req && bus.wr && acc_hit;
    end

    // software writes to bypass and last maps; done maps ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < DSM_NCAT; c++) begin
                bypass_map[c] <= DSM_BYPASS_RST;
                last_map[c] <= DSM_LAST_RST;
            end
        end else if (acc_wr) begin
            case (acc_slot)
                DSM_SLOT_BYPASS: begin
                    bypass_map[acc_cat] <= bus.wdata;
                end
                DSM_SLOT_LAST: begin
                    last_map[acc_cat] <= bus.wdata;
                end
                default: begin
                    // done maps take no write; the access just gets its ack
                end
            endcase
        end
    end

    // done map update: read clears what it saw, a new completion wins
    always_comb begin
        for (int c = 0; c < DSM_NCAT; c++) begin
            logic [31:0] clr;
            logic [31:0] set;
            clr = 32'h0;
            set = 32'h0;
            // clr is exactly what the read returns, so a bit set in the
            // read's own cycle survives for the next read
            if (acc_rd
                && (acc_slot == DSM_SLOT_DONE)
                && (acc_cat == c[1:0])) begin
                clr = done_map[c];
            end
            if (active[c] && cmpl[c]) begin
                set = 32'h1 << scan_index[c];
            end
            next_done[c] = (done_map[c] & ~clr) | set;
        end
    end

    // done map storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < DSM_NCAT; c++) begin
                done_map[c] <= DSM_DONE_RST;
            end
        end else begin
            for (int c = 0; c < DSM_NCAT; c++) begin
                done_map[c] <= next_done[c];
            end
        end
    end

    // bus answer one cycle after the request; unmapped gives err
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.ack <= 1'b0;
            bus.err <= 1'b0;
            bus.rdata <= 32'h0;
        end else begin
            bus.ack <= bus.req;
            bus.err <= bus.req && !acc_hit;
            // zero outside the ack cycle, so a stale word never leaks
            bus.rdata <= 32'h0;
            if (acc_rd) begin
                case (acc_slot)
                    DSM_SLOT_DONE: begin
                        bus.rdata <= done_map[acc_cat];
                    end
                    DSM_SLOT_BYPASS: begin
                        bus.rdata <= bypass_map[acc_cat];
                    end
                    DSM_SLOT_LAST: begin
                        bus.rdata <= last_map[acc_cat];
                    end
                    default: begin
                        bus.rdata <= 32'h0;
                    end
                endcase
            end
        end
    end

    // pending levels toward the controller, one per category
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.pending <= 3'h0;
        end else begin
            for (int c = 0; c < DSM_NCAT; c++) begin
                // from next_done so the level moves with the map itself
                bus.pending[c] <= |next_done[c];
            end
        end
    end

    // scan per category: present a valid unbypassed slot, else move on
    // scan_index holds while a slot is presented, so the done bit
    // lands on the same position that the engine worked on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= 3'h0;
            wrap <= 3'h0;
            for (int c = 0; c < DSM_NCAT; c++) begin
                scan_index[c] <= DSM_POS_FIRST;
            end
        end else begin
            for (int c = 0; c < DSM_NCAT; c++) begin
                wrap[c] <= 1'b0;
                if (active[c]) begin
                    if (cmpl[c]) begin
                        active[c] <= 1'b0;
                        if (jump[c]) begin
                            // pointer only comes from a processed slot
                            // marker not checked here; targets sit below it
                            scan_index[c] <= jump_ptr[c];
                        end else begin
                            scan_index[c] <= dsm_step(scan_index[c],
                                last_map[c]);
                            wrap[c] <= dsm_wraps(scan_index[c],
                                last_map[c]);
                        end
                    end else if (bypass_map[c][scan_index[c]]) begin
                        // bypassed while presented: withdraw it
                        active[c] <= 1'b0;
                        scan_index[c] <= dsm_step(scan_index[c],
                            last_map[c]);
                        wrap[c] <= dsm_wraps(scan_index[c], last_map[c]);
                    end
                end else if (!bypass_map[c][scan_index[c]]
                             && desc_valid[c][scan_index[c]]) begin
                    active[c] <= 1'b1;
                end else begin
                    // bypassed or invalid slot: nothing of it is read, step on
                    scan_index[c] <= dsm_step(scan_index[c],
                        last_map[c]);
                    wrap[c] <= dsm_wraps(scan_index[c], last_map[c]);
                end
            end
        end
    end

endmodule

// file: include/dsm_pkg.sv
// Purpose: shared constants for the descriptor schedule maps block
// Assumes: one core clock, 32 descriptors per category, word registers
// Notes: category index 0 iso, 1 interrupt, 2 async
// What this block does
// - scan stops at last-descriptor marker bit
// - after marked descriptor, wrap to position zero
// - iso/async last map is one-hot position bitmap
// - interrupt last map treated as same bitmap
// - last maps read/write, reset all zeros
// - completion sets that descriptor's done bit
// - done map read returns bits, clears them
// - done maps read-only, reset all zeros
// - bypass bit skips descriptor regardless of valid
// - skipped descriptor's next pointer is ignored
// - bypass maps read/write, reset all ones
// - software keeps pointer targets unbypassed
// - software places marker above pointer targets
// - each category has its own map set
// - iso done and bypass maps at 130h/134h
package dsm_pkg;
    localparam int DSM_NCAT = 3;
    localparam int DSM_ADDR_W = 12;
    localparam int DSM_CAT_ISO = 0;
    localparam int DSM_CAT_INT = 1;
    localparam int DSM_CAT_ASYNC = 2;
    // device map offsets
    localparam logic [11:0] DSM_ISO_DONE_OFS = 12'h130;
    localparam logic [11:0] DSM_ISO_BYPASS_OFS = 12'h134;
    localparam logic [11:0] DSM_ISO_LAST_OFS = 12'h138;
    localparam logic [11:0] DSM_INT_DONE_OFS = 12'h140;
    localparam logic [11:0] DSM_INT_BYPASS_OFS = 12'h144;
    localparam logic [11:0] DSM_INT_LAST_OFS = 12'h148;
    localparam logic [11:0] DSM_ASYNC_DONE_OFS = 12'h150;
    localparam logic [11:0] DSM_ASYNC_BYPASS_OFS = 12'h154;
    localparam logic [11:0] DSM_ASYNC_LAST_OFS = 12'h158;
    // category stride and word slot within a category
    localparam logic [11:0] DSM_CAT_STRIDE = 12'h010;
    localparam logic [1:0] DSM_SLOT_DONE = 2'h0;
    localparam logic [1:0] DSM_SLOT_BYPASS = 2'h1;
    localparam logic [1:0] DSM_SLOT_LAST = 2'h2;
    // reset values
    localparam logic [31:0] DSM_DONE_RST = 32'h00000000;
    localparam logic [31:0] DSM_BYPASS_RST = 32'hffffffff;
    localparam logic [31:0] DSM_LAST_RST = 32'h00000000;
    localparam logic [4:0] DSM_POS_FIRST = 5'h00;
    localparam logic [4:0] DSM_POS_TOP = 5'h1f;
    // controller registers and forwarding window
    localparam logic [11:0] DSM_DEV_WIN_END = 12'h200;
    localparam logic [11:0] DSM_IRQ_STATUS_OFS = 12'h400;
    localparam logic [11:0] DSM_IRQ_MASK_OFS = 12'h404;
    localparam logic [2:0] DSM_IRQ_RST = 3'h0;
endpackage

// file: include/dsm_if.sv
// Purpose: register port between controller and descriptor map device
// Assumes: both ends on pclk; one request pulse, one ack pulse
// Notes: pending is a level per category, high while its done map is set
`timescale 1ns/10ps
interface dsm_if;
    logic req;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic err;
    logic [2:0] pending;

    modport dev (
        input req,
        input wr,
        input addr,
        input wdata,
        output rdata,
        output ack,
        output err,
        output pending
    );

    modport host (
        output req,
        output wr,
        output addr,
        output wdata,
        input rdata,
        input ack,
        input err,
        input pending
    );
endinterface

// file: core/dsm_host.sv
// Purpose: controller end: APB slave forwarding to the map device
// Assumes: APB master on pclk; device answers with one ack pulse
// Notes: own interrupt status and mask registers live here
`timescale 1ns/10ps
module dsm_host
    import dsm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    dsm_if.host bus
);

    typedef enum logic [1:0] {
        DSM_H_IDLE,
        DSM_H_WAIT,
        DSM_H_DONE
    } dsm_hstate_t;

    dsm_hstate_t state;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] pend_q;
    logic take;
    logic own;

    // an access phase is taken only from idle
    always_comb begin
        take = (state == DSM_H_IDLE) && psel && penable;
        own = paddr >= DSM_DEV_WIN_END;
    end

    // transfer sequencing toward APB and the device port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DSM_H_IDLE;
            bus.req <= 1'b0;
            bus.wr <= 1'b0;
            bus.addr <= 12'h0;
            bus.wdata <= 32'h0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            bus.req <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            case (state)
                DSM_H_IDLE: begin
                    if (take && own) begin
                        pready <= 1'b1;
                        prdata <= 32'h0;
                        state <= DSM_H_DONE;
                        if (paddr == DSM_IRQ_STATUS_OFS) begin
                            prdata <= {29'h0, irq_status};
                        end else if (paddr == DSM_IRQ_MASK_OFS) begin
                            prdata <= {29'h0, irq_mask};
                        end else begin
                            pslverr <= 1'b1;
                        end
                    end else if (take) begin
                        bus.req <= 1'b1;
                        bus.wr <= pwrite;
                        bus.addr <= paddr;
                        bus.wdata <= pwdata;
                        state <= DSM_H_WAIT;
                    end
                end
                DSM_H_WAIT: begin
                    if (bus.ack) begin
                        prdata <= bus.rdata;
                        pslverr <= bus.err;
                        pready <= 1'b1;
                        state <= DSM_H_DONE;
                    end
                end
                DSM_H_DONE: begin
                    state <= DSM_H_IDLE;
                end
                default: begin
                    state <= DSM_H_IDLE;
                end
            endcase
        end
    end

    // interrupt mask, software writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= DSM_IRQ_RST;
        end else if (take && pwrite && (paddr == DSM_IRQ_MASK_OFS)) begin
            irq_mask <= pwdata[2:0];
        end
    end

    // sticky status: rising pending sets, status read clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 3'h0;
            irq_status <= DSM_IRQ_RST;
        end else begin
            pend_q <= bus.pending;
            if (take && !pwrite && (paddr == DSM_IRQ_STATUS_OFS)) begin
                irq_status <= bus.pending & ~pend_q;
            end else begin
                irq_status <= irq_status | (bus.pending & ~pend_q);
            end
        end
    end

    // level interrupt from registered status and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule

// file: test/dsm_asserts.sv
// Purpose: checks on the port between controller and map device
// Assumes: one clock, presetn active low
// Notes: sees the interface signals only
`timescale 1ns/10ps
module dsm_asserts
    import dsm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic wr,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack,
    input wire logic err,
    input wire logic [2:0] pending
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // requests to a map word or to a hole
    sequence good_req;
        req && addr[1:0] == 2'h0 && addr[3:2] != 2'h3
            && addr[11:4] inside {8'h13, 8'h14, 8'h15};
    endsequence
    sequence bad_req;
        req && (addr[1:0] != 2'h0 || addr[3:2] == 2'h3);
    endsequence
    sequence done_wr;
        req && wr && addr[3:0] == 4'h0
            && addr[11:4] inside {8'h13, 8'h14, 8'h15};
    endsequence
    // answer timing and answer content
    a_ack_after_req: assert property (req |=> ack)
        else $error("ack missing after request");
    a_req_single: assert property (req |=> !req)
        else $error("request longer than one cycle");
    a_ack_has_cause: assert property (ack |-> $past(req))
        else $error("ack without request");
    a_err_with_ack: assert property (err |-> ack && rdata == 32'h0)
        else $error("err outside ack or with data");
    a_idle_rdata: assert property (!ack |-> rdata == 32'h0)
        else $error("read data outside ack");
    a_hole_err: assert property (bad_req |=> err)
        else $error("hole address not refused");
    a_map_ok: assert property (good_req |=> ack && !err)
        else $error("map address refused");
    a_done_wr_quiet: assert property (done_wr |=> !err)
        else $error("done map write refused");
    // a done level only drops through a read of that done map
    a_iso_drop_read: assert property ($fell(pending[0]) |->
        $past(req && !wr && addr == DSM_ISO_DONE_OFS))
        else $error("iso pending dropped without a done read");
    a_int_drop_read: assert property ($fell(pending[1]) |->
        $past(req && !wr && addr == DSM_INT_DONE_OFS))
        else $error("int pending dropped without a done read");
    a_async_drop_read: assert property ($fell(pending[2]) |->
        $past(req && !wr && addr == DSM_ASYNC_DONE_OFS))
        else $error("async pending dropped without a done read");
    // write data only moves together with a request
    a_wdata_with_req: assert property ($changed(wdata) |-> req)
        else $error("write data moved without a request");
endmodule

// file: test/descriptor_schedule_maps_bench.sv
// Purpose: self-checking bench for both ends of the map block
// Assumes: apb master here; engine side driven by tasks
// Notes: from the first serve on, jump idles high with a decoy pointer that must be ignored
`timescale 1ns/10ps
module descriptor_schedule_maps_bench;
    import dsm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [2:0][31:0] desc_valid = '0;
    logic [2:0] cmpl = 3'h0;
    logic [2:0] jump = 3'h0;
    logic [2:0][4:0] jump_ptr = '0;
    logic [2:0] active;
    logic [2:0][4:0] scan_index;
    logic [2:0] wrap;
    int errors = 0;
    int n_tests = 0;
    dsm_if bus_if();
    dsm_maps i_dsm_maps(.pclk(pclk), .presetn(presetn), .bus(bus_if.dev),
        .desc_valid(desc_valid), .cmpl(cmpl), .jump(jump),
        .jump_ptr(jump_ptr), .active(active), .scan_index(scan_index),
        .wrap(wrap));
    dsm_host i_dsm_host(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .bus(bus_if.host));
    dsm_asserts i_dsm_asserts(.pclk(pclk), .presetn(presetn),
        .req(bus_if.req), .wr(bus_if.wr), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack),
        .err(bus_if.err), .pending(bus_if.pending));
    // 125 MHz clock
    always #4 pclk = ~pclk;
    task automatic tally_and_finish();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    // waits for a presented slot and completes it, jumping to jp if j;
    // afterwards jump idles high with a decoy pointer, to be ignored
    task automatic serve(input int c, input logic j, input logic [4:0] jp,
        output logic [4:0] idx);
        do begin
            @(posedge pclk);
        end while (active[c] !== 1'b1);
        idx = scan_index[c];
        cmpl[c] <= 1'b1;
        jump[c] <= j;
        jump_ptr[c] <= jp;
        @(posedge pclk);
        cmpl[c] <= 1'b0;
        jump[c] <= 1'b1;
        jump_ptr[c] <= 5'h1f;
    endtask
    // reset values and independent read/write of all maps
    task automatic t_maps();
        logic [11:0] b;
        logic [31:0] q;
        for (int c = 0; c < 3; c++) begin
            b = DSM_ISO_DONE_OFS + 12'(c * 16);
            rd(b, q);
            cmp("done rst", 32'h0, q);
            rd(b + 12'h4, q);
            cmp("bypass rst", 32'hffffffff, q);
            rd(b + 12'h8, q);
            cmp("last rst", 32'h0, q);
            wr(b, 32'hffffffff);
            wr(b + 12'h4, 32'ha5a50000 + 32'(c));
            wr(b + 12'h8, 32'h10 << c);
        end
        for (int c = 0; c < 3; c++) begin
            b = DSM_ISO_DONE_OFS + 12'(c * 16);
            rd(b, q);
            cmp("done ro", 32'h0, q);
            rd(b + 12'h4, q);
            cmp("bypass rw", 32'ha5a50000 + 32'(c), q);
            rd(b + 12'h8, q);
            cmp("last rw", 32'h10 << c, q);
            wr(b + 12'h4, 32'hffffffff);
            wr(b + 12'h8, 32'h0);
        end
    endtask
    // holes in the map and own space are refused
    task automatic t_holes();
        logic [31:0] q;
        logic e;
        apb(1'b0, 12'h13c, 32'h0, q, e);
        cmp("slot3 err", 32'h1, {31'h0, e});
        apb(1'b1, 12'h151, 32'h0, q, e);
        cmp("align err", 32'h1, {31'h0, e});
        apb(1'b0, 12'h408, 32'h0, q, e);
        cmp("own err", 32'h1, {31'h0, e});
    endtask
    // scan a category, last slot set by the last map, bypass may drop one
    task automatic t_scan(input int c, input logic [31:0] last,
        input logic [31:0] byp, input logic [31:0] done);
        logic [11:0] b;
        logic [4:0] i0;
        logic [4:0] i;
        logic [31:0] q;
        b = DSM_ISO_DONE_OFS + 12'(c * 16);
        wr(b + 12'h8, last);
        desc_valid[c] <= 32'h7;
        wr(b + 12'h4, byp);
        serve(c, 1'b0, 5'h0, i0);
        for (int k = 0; k < 4; k++) begin
            serve(c, 1'b0, 5'h0, i);
            if (last == 32'h3) begin
                cmp("int wrap", 32'h0, 32'(i));
            end else if (byp[1]) begin
                cmp("skip", i0 == 0 ? 32'h2 : 32'h0, 32'(i));
            end else begin
                cmp("order", 32'((i0 + 5'h1) % 5'h3), 32'(i));
            end
            i0 = i;
        end
        repeat (4) @(posedge pclk);
        cmp("irq", {31'h0, c == 2}, {31'h0, irq});
        rd(b, q);
        cmp("done bits", done, q & done);
        rd(b, q);
        cmp("done clear", 32'h0, q);
        wr(b + 12'h4, 32'hffffffff);
        desc_valid[c] <= 32'h0;
        rd(DSM_IRQ_STATUS_OFS, q);
        repeat (3) @(posedge pclk);
        cmp("irq clear", 32'h0, {31'h0, irq});
    endtask
    // iso scan with a jump from slot 1 to 3 under the marker at 4
    task automatic t_jump();
        logic [4:0] i;
        logic [31:0] q;
        wr(DSM_ISO_LAST_OFS, 32'h10);
        desc_valid[0] <= 32'h1f;
        wr(DSM_ISO_BYPASS_OFS, 32'hffffffe0);
        do begin
            serve(0, 1'b0, 5'h0, i);
        end while (i != 5'h0);
        serve(0, 1'b1, 5'h3, i);
        cmp("jump from", 32'h1, 32'(i));
        serve(0, 1'b0, 5'h0, i);
        cmp("jump to", 32'h3, 32'(i));
        serve(0, 1'b0, 5'h0, i);
        cmp("marker slot", 32'h4, 32'(i));
        @(posedge pclk);
        cmp("wrap pulse", 32'h1, {31'h0, wrap[0]});
        serve(0, 1'b0, 5'h0, i);
        cmp("after wrap", 32'h0, 32'(i));
        rd(DSM_ISO_DONE_OFS, q);
        cmp("iso done", 32'h1b, q & 32'h1b);
        rd(DSM_ISO_DONE_OFS, q);
        cmp("iso clear", 32'h0, q);
        wr(DSM_ISO_BYPASS_OFS, 32'hffffffff);
        desc_valid[0] <= 32'h0;
        rd(DSM_IRQ_STATUS_OFS, q);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_maps();
        t_holes();
        t_jump();
        wr(DSM_IRQ_MASK_OFS, 32'h4);
        t_scan(2, 32'h4, 32'hfffffff8, 32'h7);
        t_scan(2, 32'h4, 32'hfffffffa, 32'h5);
        t_scan(1, 32'h3, 32'hfffffffc, 32'h1);
        tally_and_finish();
    end
    // hang guard
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule
